// ===== hw/ivdc_ctrl.sv
// interleaved video dram control: strobes, ready, enables, refresh
`timescale 1ns/10ps
`default_nettype none
module ivdc_ctrl
  import ivdc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // processor side
  input wire logic instr_request_i,
  input wire logic instr_burst_request_i,
  input wire logic instr_burst_ack_i,
  input wire logic bus_invalid_i,
  input wire logic addr_bit2_i,
  input wire logic read_not_write_i,
  output logic instr_ready_o,
  output logic even_bank_instr_drive_o,
  output logic odd_bank_instr_drive_o,
  output logic data_ready_o,
  output logic even_data_buffer_drive_o,
  output logic odd_data_buffer_drive_o,
  output logic pipeline_enable_resp_o,
  // sequencer and decoder side
  input wire logic instr_access_start_i,
  input wire logic data_access_start_i,
  input wire logic instr_state_one_i,
  input wire logic instr_state_three_i,
  input wire logic instr_state_four_i,
  input wire logic data_state_one_i,
  input wire logic data_state_two_i,
  input wire logic data_state_three_i,
  input wire logic data_state_four_i,
  input wire logic latched_addr_bit2_i,
  input wire logic refresh_ack_i,
  input wire logic refresh_state_three_i,
  input wire logic precharge_state_one_i,
  output logic bank_select_o,
  output logic refresh_request_flag_o,
  // memory array side
  output logic write_enable_even_o,
  output logic write_enable_odd_o,
  output logic row_strobe_even_o,
  output logic row_strobe_odd_o,
  output logic row_strobe_delay_o,
  output logic col_strobe_even_o,
  output logic col_strobe_odd_o,
  // axi4-lite register slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef struct packed {
    logic instr_burst_request_d;
    logic instr_burst_ack_d;
    logic bus_invalid_d;
    logic bank_sel;
    logic we;
    logic ras;
    logic [1:0] ras_cnt;
    logic cas_even;
    logic cas_odd;
    logic rf_flag;
    logic long_hold;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } ivdc_state_s;

  ivdc_state_s st_q;
  ivdc_state_s st_d;
  logic [RFC_WIDTH-1:0] rf_count;
  logic rf_terminal;
  logic burst_cnt;
  logic bank_load;
  logic instr_rdy;
  logic ras_start;
  logic ras_hold;
  logic wr_take;
  logic data_wr;

  // ****************************************************************
  // refresh interval counter
  // ****************************************************************
  ivdc_refresh_counter #(
    .WIDTH(RFC_WIDTH)
  ) u_rfc (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .count_o(rf_count),
    .terminal_o(rf_terminal)
  );

  // ****************************************************************
  // instruction side
  // ****************************************************************
  // burst request arrives too late to qualify, so it is used one cycle old
  assign burst_cnt = !instr_state_one_i && st_q.instr_burst_request_d && st_q.instr_burst_ack_d;
  assign instr_rdy = (!instr_state_three_i && instr_state_four_i)
                   || (!st_q.bus_invalid_d && burst_cnt);
  assign instr_ready_o = instr_rdy;
  assign even_bank_instr_drive_o = instr_rdy && st_q.bank_sel;
  assign odd_bank_instr_drive_o = instr_rdy && !st_q.bank_sel;
  assign bank_load = instr_request_i && !instr_state_one_i;
  assign bank_select_o = st_q.bank_sel;

  // ****************************************************************
  // data side, decoded from sequencer state, latched write and address bit, live read/write line
  // ****************************************************************
  assign data_wr = st_q.we;
  // read answers in the access state; writes in column state, long hold to wait
  assign data_ready_o = data_wr
    ? ((data_state_two_i && !data_state_three_i)
       || (st_q.long_hold && (data_state_three_i || data_state_four_i)))
    : (data_state_three_i && !data_state_four_i);
  assign even_data_buffer_drive_o = !data_wr && !latched_addr_bit2_i
                                  && data_state_three_i;
  assign odd_data_buffer_drive_o = !data_wr && latched_addr_bit2_i
                                 && data_state_three_i;
  // read/write is already latched by this state, but the live line qualifies it
  assign pipeline_enable_resp_o = data_state_two_i && !data_state_three_i
                                && read_not_write_i;
  assign write_enable_even_o = st_q.we;
  assign write_enable_odd_o = st_q.we;
  assign row_strobe_even_o = st_q.ras;
  assign row_strobe_odd_o = st_q.ras;
  assign row_strobe_delay_o = st_q.ras;
  assign col_strobe_even_o = st_q.cas_even;
  assign col_strobe_odd_o = st_q.cas_odd;
  assign refresh_request_flag_o = st_q.rf_flag;

  // row strobe start and hold terms
  assign ras_start = !bus_invalid_i && !st_q.ras
    && (instr_access_start_i || data_access_start_i
        || (!precharge_state_one_i && refresh_ack_i));
  assign ras_hold = (instr_state_one_i && !instr_state_three_i)
    || (data_state_one_i && !data_state_three_i)
    || (refresh_ack_i && !refresh_state_three_i);

  // ****************************************************************
  // axi4-lite handshakes
  // ****************************************************************
  // address and data are taken together, so either arrival order is fine
  assign wr_take = s_axi_awvalid && s_axi_wvalid && !st_q.bvalid;
  assign s_axi_awready = wr_take;
  assign s_axi_wready = wr_take;
  assign s_axi_arready = !st_q.rvalid;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rresp = st_q.rresp;
  assign s_axi_rdata = st_q.rdata;

  // next state of everything
  always_comb begin
    st_d = st_q;
    st_d.instr_burst_request_d = instr_burst_request_i;
    st_d.instr_burst_ack_d = instr_burst_ack_i;
    st_d.bus_invalid_d = bus_invalid_i;
    // bank select: load, forced first toggles, then per delivered word
    if (bank_load) begin
      st_d.bank_sel = addr_bit2_i;
    end else if (instr_state_three_i || instr_state_four_i
                 || (burst_cnt && !bus_invalid_i)) begin
      st_d.bank_sel = !st_q.bank_sel;
    end
    // write enable only in data accesses, never in instruction transfers
    if (instr_state_one_i || !data_state_one_i) begin
      st_d.we = 1'b0;
    end else if (!data_state_two_i) begin
      st_d.we = !read_not_write_i;
    end
    // row strobe with a guaranteed minimum width
    if (ras_start) begin
      st_d.ras = 1'b1;
      st_d.ras_cnt = 2'h1;
    end else if (st_q.ras && (st_q.ras_cnt < RAS_MIN_CYC || ras_hold)) begin
      st_d.ras = 1'b1;
      st_d.ras_cnt = (st_q.ras_cnt == RAS_MIN_CYC) ? st_q.ras_cnt
                                                   : st_q.ras_cnt + 2'h1;
    end else begin
      st_d.ras = 1'b0;
      st_d.ras_cnt = 2'h0;
    end
    // column strobes: after row strobe, or before it for refresh
    // write bit taken from this cycle's capture, the register lags one cycle
    st_d.cas_even = (st_q.ras && instr_state_one_i)
      || (st_q.ras && data_state_one_i && (!st_d.we || !latched_addr_bit2_i))
      || (!st_q.ras && !instr_state_one_i && !data_state_one_i
          && st_q.rf_flag);
    st_d.cas_odd = (st_q.ras && instr_state_one_i)
      || (st_q.ras && data_state_one_i && (!st_d.we || latched_addr_bit2_i))
      || (!st_q.ras && !instr_state_one_i && !data_state_one_i
          && st_q.rf_flag);
    // refresh flag: the terminal event wins over the acknowledge
    if (rf_terminal) begin
      st_d.rf_flag = 1'b1;
    end else if (refresh_ack_i) begin
      st_d.rf_flag = 1'b0;
    end
    // register writes
    if (wr_take) begin
      st_d.bvalid = 1'b1;
      if (s_axi_awaddr == REG_CTRL_OFS) begin
        st_d.bresp = AXI_RESP_OKAY;
        if (s_axi_wstrb[0]) begin
          st_d.long_hold = s_axi_wdata[CTRL_LONG_HOLD_BIT];
        end
      end else if (s_axi_awaddr == REG_STAT_OFS) begin
        st_d.bresp = AXI_RESP_OKAY;
      end else begin
        st_d.bresp = AXI_RESP_SLVERR;
      end
    end else if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end
    // register reads
    if (s_axi_arvalid && !st_q.rvalid) begin
      st_d.rvalid = 1'b1;
      st_d.rresp = AXI_RESP_OKAY;
      case (s_axi_araddr)
        REG_CTRL_OFS: st_d.rdata = {31'h0, st_q.long_hold};
        REG_STAT_OFS: st_d.rdata = {16'h0, 3'h0, rf_count, st_q.rf_flag,
                                    st_q.ras, st_q.we, st_q.bank_sel};
        default: begin
          st_d.rdata = 32'h0;
          st_d.rresp = AXI_RESP_SLVERR;
        end
      endcase
    end else if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      st_q <= '0;
      st_q.long_hold <= CTRL_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  ready_registered_a: assert property (
    (!instr_state_one_i && !instr_state_four_i && instr_ready_o)
      |-> ($past(instr_burst_request_i) && $past(instr_burst_ack_i)
           && !$past(bus_invalid_i)))
    else $error("instruction ready without previous burst request");
  bank_drive_a: assert property (
    instr_ready_o |-> (even_bank_instr_drive_o != odd_bank_instr_drive_o)
                      && (even_bank_instr_drive_o == bank_select_o))
    else $error("bank drive not matching bank select");
  read_ready_a: assert property (
    (!write_enable_even_o && data_ready_o) |-> data_state_three_i)
    else $error("read data ready outside access state");
  buffer_read_a: assert property (
    (even_data_buffer_drive_o || odd_data_buffer_drive_o)
      |-> !write_enable_even_o && !(even_data_buffer_drive_o
                                   && odd_data_buffer_drive_o))
    else $error("data buffer drive on write or both banks");
  pipe_enable_a: assert property (
    pipeline_enable_resp_o |-> data_state_two_i && !data_state_three_i)
    else $error("pipeline enable outside column state");
  no_instr_write_a: assert property (
    instr_state_one_i |=> !write_enable_even_o)
    else $error("write enable during instruction transfer");
  we_captured_a: assert property (
    (data_state_one_i && !data_state_two_i && !instr_state_one_i)
      |=> write_enable_even_o == !$past(read_not_write_i))
    else $error("write enable not captured from read/write line");
  we_pair_a: assert property (
    write_enable_even_o == write_enable_odd_o)
    else $error("write enables differ");
  no_start_invalid_a: assert property (
    ($rose(row_strobe_even_o)) |-> !$past(bus_invalid_i))
    else $error("row strobe started in invalid bus cycle");
  ras_width_a: assert property (
    $rose(row_strobe_even_o) |-> (row_strobe_even_o && row_strobe_odd_o
                                  && row_strobe_delay_o)[*3])
    else $error("row strobe shorter than three cycles");
  cas_after_ras_a: assert property (
    (row_strobe_even_o && instr_state_one_i) |=> col_strobe_even_o
                                                && col_strobe_odd_o)
    else $error("column strobe missing after row strobe");
  write_bank_cas_a: assert property (
    (row_strobe_even_o && data_state_one_i && !instr_state_one_i
     && write_enable_even_o && !refresh_request_flag_o)
      |=> col_strobe_even_o == !$past(latched_addr_bit2_i))
    else $error("write column strobe on wrong bank");
  refresh_cas_a: assert property (
    (refresh_request_flag_o && !row_strobe_even_o && !instr_state_one_i
     && !data_state_one_i) |=> col_strobe_even_o && col_strobe_odd_o)
    else $error("refresh column strobe missing in idle");
  refresh_flag_a: assert property (
    (refresh_request_flag_o && !refresh_ack_i) |=> refresh_request_flag_o)
    else $error("refresh flag dropped without acknowledge");

  cov_burst_c: cover property (instr_ready_o && !instr_state_four_i);
  cov_write_c: cover property (data_ready_o && write_enable_even_o);
  cov_read_c: cover property (pipeline_enable_resp_o ##[1:4] data_ready_o);
  cov_refresh_c: cover property (refresh_request_flag_o ##1 refresh_ack_i);
endmodule // ivdc_ctrl
`default_nettype wire

// ===== hw/ivdc_pkg.sv
// package of constants for the interleaved video dram control block
`default_nettype none
package ivdc_pkg;
  // ****************************************************************
  // refresh interval counter
  // ****************************************************************
  localparam int unsigned RFC_WIDTH = 9;
  localparam logic [8:0] RFC_TERMINAL = 9'h185;
  localparam logic [8:0] RFC_RELOAD = 9'h000;
  // ****************************************************************
  // row strobe timing
  // ****************************************************************
  localparam logic [1:0] RAS_MIN_CYC = 2'h3;
  // ****************************************************************
  // register map, byte addresses
  // ****************************************************************
  localparam logic [3:0] REG_CTRL_OFS = 4'h0;
  localparam logic [3:0] REG_STAT_OFS = 4'h4;
  localparam int unsigned CTRL_LONG_HOLD_BIT = 0;
  localparam logic CTRL_RESET = 1'b0;
  localparam logic [1:0] AXI_RESP_OKAY = 2'h0;
  localparam logic [1:0] AXI_RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ===== hw/ivdc_refresh_counter.sv
// refresh interval counter with terminal detect and reload
`timescale 1ns/10ps
`default_nettype none
module ivdc_refresh_counter
  import ivdc_pkg::*;
#(
  parameter int unsigned WIDTH = RFC_WIDTH
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  output logic [WIDTH-1:0] count_o,
  output logic terminal_o
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } ivdc_rfc_s;

  ivdc_rfc_s st_q;
  ivdc_rfc_s st_d;
  logic [WIDTH-1:0] toggle;

  // ****************************************************************
  // stage toggles
  // ****************************************************************
  // stage 0 always toggles, higher stages only when all lower are one
  assign toggle[0] = 1'b1;
  for (genvar g = 1; g < WIDTH; g++) begin : g_stage
    assign toggle[g] = &st_q.cnt[g-1:0];
  end

  assign terminal_o = (st_q.cnt == RFC_TERMINAL[WIDTH-1:0]);
  assign count_o = st_q.cnt;

  // next count, reload at terminal pattern
  always_comb begin
    st_d = st_q;
    if (terminal_o) begin
      st_d.cnt = RFC_RELOAD[WIDTH-1:0];
    end else begin
      st_d.cnt = st_q.cnt ^ toggle;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  counter_step_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !terminal_o |=> count_o == WIDTH'($past(count_o) + 1'b1))
    else $error("refresh counter did not step by one");
endmodule // ivdc_refresh_counter
`default_nettype wire

// ===== testbench/ivdc_proc_model.sv
// processor and access sequencer model facing the interleaved video dram control block
`timescale 1ns/10ps
`default_nettype none
module ivdc_proc_model (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic instr_access_start_i,
  input wire logic data_access_start_i,
  input wire logic bus_invalid_i,
  input wire logic refresh_ack_i,
  input wire logic pipeline_enable_resp_i,
  output logic [4:1] instr_state_o,
  output logic [4:1] data_state_o,
  output logic refresh_state_three_o,
  output logic precharge_state_one_o,
  output logic addr_free_o
);
  typedef struct packed {
    logic [4:1] iq;
    logic [4:1] dq;
    logic [1:0] rq;
    logic pc;
    logic free;
  } ivdc_pm_s;
  ivdc_pm_s st_q, st_d;
  // ********************
  // access sequences
  // ********************
  // a start seen under an invalid bus is dropped, like the real sequencer
  always_comb begin
    st_d = st_q;
    st_d.iq[1] = (!bus_invalid_i && !st_q.iq[1] && instr_access_start_i) || (st_q.iq[1] && !st_q.iq[4]);
    st_d.iq[2] = st_q.iq[1] && !st_q.iq[4];
    st_d.iq[3] = st_q.iq[2] && !st_q.iq[4];
    st_d.iq[4] = st_q.iq[3];
    st_d.dq[1] = (!bus_invalid_i && !st_q.dq[1] && data_access_start_i) || (st_q.dq[1] && !st_q.dq[4]);
    st_d.dq[2] = st_q.dq[1] && !st_q.dq[4];
    st_d.dq[3] = st_q.dq[2] && !st_q.dq[4];
    st_d.dq[4] = st_q.dq[3] && !st_q.dq[4];
    // refresh steps only advance while acknowledge is held, saturating at three
    st_d.rq = refresh_ack_i ? (st_q.rq == 2'h3 ? 2'h3 : st_q.rq + 2'h1) : 2'h0;
    st_d.pc = !st_q.pc && (st_q.iq[3] || st_q.dq[3] || st_q.rq == 2'h3);
    st_d.free = pipeline_enable_resp_i;
  end
  // state register
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  // outputs straight from state
  assign instr_state_o = st_q.iq;
  assign data_state_o = st_q.dq;
  assign refresh_state_three_o = (st_q.rq == 2'h3);
  assign precharge_state_one_o = st_q.pc;
  assign addr_free_o = st_q.free;
endmodule // ivdc_proc_model
`default_nettype wire

// ===== testbench/tb_top.sv
// self-checking bench for the interleaved video dram control block
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import ivdc_pkg::*;
();
  logic clk, rstn, ireq, breq, back, bus_invalid, a2, rnw, instr_access_start, data_access_start, lab2, rack;
  logic ir, ie, io, dr, deb, dob, pipeline_enable_resp, bs, flag, wee, weo, rse, rso, rsd, cse, cso;
  logic [4:1] iq, dq;
  logic rq3, pc1, afree, we_m, bs_m, long_m, breq_p, back_p, bus_invalid_p, exp_ir;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [15:0] seed;
  int bad_count = 0, n_compared = 0, cyc = 0, t0, t1;

  ivdc_ctrl i_ivdc_ctrl (
    .core_clk_i(clk), .rstn_i(rstn), .instr_request_i(ireq), .instr_burst_request_i(breq),
    .instr_burst_ack_i(back), .bus_invalid_i(bus_invalid), .addr_bit2_i(a2), .read_not_write_i(rnw),
    .instr_ready_o(ir), .even_bank_instr_drive_o(ie), .odd_bank_instr_drive_o(io),
    .data_ready_o(dr), .even_data_buffer_drive_o(deb), .odd_data_buffer_drive_o(dob),
    .pipeline_enable_resp_o(pipeline_enable_resp), .instr_access_start_i(instr_access_start), .data_access_start_i(data_access_start),
    .instr_state_one_i(iq[1]), .instr_state_three_i(iq[3]), .instr_state_four_i(iq[4]),
    .data_state_one_i(dq[1]), .data_state_two_i(dq[2]), .data_state_three_i(dq[3]),
    .data_state_four_i(dq[4]), .latched_addr_bit2_i(lab2), .refresh_ack_i(rack),
    .refresh_state_three_i(rq3), .precharge_state_one_i(pc1), .bank_select_o(bs),
    .refresh_request_flag_o(flag), .write_enable_even_o(wee), .write_enable_odd_o(weo),
    .row_strobe_even_o(rse), .row_strobe_odd_o(rso), .row_strobe_delay_o(rsd),
    .col_strobe_even_o(cse), .col_strobe_odd_o(cso),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );
  ivdc_proc_model i_ivdc_proc_model (
    .core_clk_i(clk), .rstn_i(rstn), .instr_access_start_i(instr_access_start),
    .data_access_start_i(data_access_start), .bus_invalid_i(bus_invalid), .refresh_ack_i(rack),
    .pipeline_enable_resp_i(pipeline_enable_resp), .instr_state_o(iq), .data_state_o(dq),
    .refresh_state_three_o(rq3), .precharge_state_one_o(pc1), .addr_free_o(afree)
  );

  // ********************
  // clock, helpers, reporting
  // ********************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input bit ok, input string msg);
    n_compared++;
    if (!ok) begin
      bad_count++;
      $display("BAD at %0t: %s", $time, msg);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // hang guard, well above the roughly one thousand cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    $display("BAD at %0t: watchdog expired", $time);
    give_verdict();
  end

  // ********************
  // reference model and per-cycle checks
  // ********************
  // burst inputs are late, so the reference sees them one cycle delayed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    breq_p <= breq;
    back_p <= back;
    bus_invalid_p <= bus_invalid;
    if (!rstn) begin
      we_m <= 1'b0;
      bs_m <= 1'b0;
    end else begin
      we_m <= (iq[1] || !dq[1]) ? 1'b0 : (dq[1] && !dq[2]) ? !rnw : we_m;
      if (ireq && !iq[1]) begin
        bs_m <= a2;
      end else if (iq[3] || iq[4] || (!iq[1] && breq_p && back_p && !bus_invalid)) begin
        bs_m <= !bs_m;
      end
    end
  end
  // outputs are settled at the falling edge
  always @(negedge clk) begin
    if (rstn) begin
      exp_ir = (!iq[3] && iq[4]) || (!bus_invalid_p && !iq[1] && breq_p && back_p);
      chk(ir === exp_ir, "instruction ready");
      chk(ie === (exp_ir && bs_m) && io === (exp_ir && !bs_m), "instruction drives");
      chk(bs === bs_m, "bank select");
      chk(pipeline_enable_resp === (dq[2] && !dq[3] && rnw), "pipeline enable");
      chk(deb === (!we_m && dq[3] && !lab2) && dob === (!we_m && dq[3] && lab2), "buffers");
      chk(dr === (we_m ? ((dq[2] && !dq[3]) || (long_m && (dq[3] || dq[4])))
                       : (dq[3] && !dq[4])), "data ready");
      chk(wee === we_m && weo === we_m, "write enables");
      chk(rso === rse && rsd === rse, "row strobe copies");
    end
  end

  // ********************
  // bus and access tasks
  // ********************
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(negedge clk); while (!(awready === 1'b1 && wready === 1'b1));
    @(posedge clk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(negedge clk); while (bvalid !== 1'b1);
    chk(bresp === er, "write response");
    @(posedge clk);
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk); while (arready !== 1'b1);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (rvalid !== 1'b1);
    chk(rdata === ed && rresp === er, "register read");
    @(posedge clk);
    rready <= 1'b0;
  endtask
  // one instruction or data access, watched for six cycles from the start edge
  task automatic access(input logic is_d, input logic rw, input logic b2);
    int rn, dn, an;
    rn = 0;
    dn = 0;
    an = 0;
    @(posedge clk);
    rnw <= rw;
    lab2 <= b2;
    a2 <= b2;
    ireq <= !is_d;
    instr_access_start <= !is_d;
    data_access_start <= is_d;
    @(posedge clk);
    {ireq, instr_access_start, data_access_start} <= 3'h0;
    for (int i = 0; i < 6; i++) begin
      @(negedge clk);
      rn += rse;
      dn += dr;
      an += afree;
      if (i == 1) chk(cse === (!(is_d && !rw) || !b2) && cso === (!(is_d && !rw) || b2), "cols");
    end
    chk(rn == 3, "row strobe width");
    if (is_d) chk(dn == ((!rw && long_m) ? 3 : 1), "data ready count");
    if (is_d) chk(an == int'(rw), "address freed once per read");
  endtask
  task automatic refresh_run(output int t);
    while (flag !== 1'b1) @(negedge clk);
    t = cyc;
    @(negedge clk);
    chk(cse === 1'b1 && cso === 1'b1 && rse === 1'b0, "idle column strobe");
    @(posedge clk);
    rack <= 1'b1;
    repeat (2) @(negedge clk);
    chk(rse === 1'b1 && flag === 1'b0, "refresh row strobe");
    while (rq3 !== 1'b1) @(negedge clk);
    @(posedge clk);
    rack <= 1'b0;
  endtask

  // ********************
  // main sequence
  // ********************
  initial begin
    rstn = 1'b0;
    {ireq, breq, back, bus_invalid, a2, rnw, instr_access_start, data_access_start, lab2, rack} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hF;
    seed = 16'h0FD5;
    long_m = 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    refresh_run(t0);
    refresh_run(t1);
    chk(t1 - t0 == int'(RFC_TERMINAL) + 1, "refresh period");
    $display("test refresh done");
    axi_rd(REG_CTRL_OFS, 32'h0000_0000, AXI_RESP_OKAY);
    axi_wr(REG_STAT_OFS, 32'hFFFF_FFFF, AXI_RESP_OKAY);
    axi_wr(4'h8, 32'h0000_0001, AXI_RESP_SLVERR);
    axi_rd(4'hC, 32'h0000_0000, AXI_RESP_SLVERR);
    axi_rd(REG_CTRL_OFS, 32'h0000_0000, AXI_RESP_OKAY);
    $display("test registers done");
    // reads and writes alternate; second half runs with the long data hold
    for (int k = 0; k < 12; k++) begin
      if (k == 6) begin
        axi_wr(REG_CTRL_OFS, 32'h0000_0001, AXI_RESP_OKAY);
        axi_rd(REG_CTRL_OFS, 32'h0000_0001, AXI_RESP_OKAY);
        long_m = 1'b1;
      end
      seed = lfsr(seed);
      access(1'b1, k[0], seed[1]);
    end
    $display("test data accesses done");
    // instruction accesses, each followed by random burst traffic
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      access(1'b0, 1'b1, seed[2]);
      repeat (24) begin
        @(posedge clk);
        breq <= seed[3];
        back <= seed[4];
        bus_invalid <= seed[5] & seed[6];
        seed = lfsr(seed);
      end
      @(posedge clk);
      {breq, back, bus_invalid} <= 3'h0;
    end
    $display("test instruction bursts done");
    @(posedge clk);
    bus_invalid <= 1'b1;
    data_access_start <= 1'b1;
    @(posedge clk);
    bus_invalid <= 1'b0;
    data_access_start <= 1'b0;
    @(negedge clk);
    chk(rse === 1'b0 && dq[1] === 1'b0, "start under invalid bus");
    $display("test invalid start done");
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
